/* File: inc/fp_pkg.sv */
package fp_pkg;
   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int ADR_W  = 16;
   localparam int DAT_W  = 32;
   localparam int IDX_W  = 14;
   localparam int VAL_W  = 16;
   localparam int THR_W  = 21;
   localparam int DIST_W = 32;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_SELECT    = 14'h2C20;
   localparam logic [IDX_W-1:0] IDX_MULT      = 14'h2C21;
   localparam logic [IDX_W-1:0] IDX_LIMIT     = 14'h2C22;
   localparam logic [IDX_W-1:0] IDX_VIB_MEAN  = 14'h2C23;
   localparam logic [IDX_W-1:0] IDX_VIB_DEV   = 14'h2C24;
   localparam logic [IDX_W-1:0] IDX_STATE     = 14'h2C29;
   localparam logic [IDX_W-1:0] IDX_VIB_THR   = 14'h2C2D;
   localparam logic [IDX_W-1:0] IDX_DISTANCE  = 14'h2C2F;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SEL_VIB_LSB  = 4;
   localparam int SEL_TRV_LSB  = 8;
   localparam int SEL_MUL_LSB  = 12;
   localparam int MULT_VIB_LSB = 4;
   localparam int ST_FRIC_LSB  = 0;
   localparam int ST_VIB_LSB   = 4;
   localparam int ST_TRV_LSB   = 8;
   localparam int ST_RUN_LSB   = 12;

   // ------------------------------------------------------------
   // Selection codes and status codes
   // ------------------------------------------------------------
   localparam logic [3:0] VIB_OFF    = 4'h0;
   localparam logic [3:0] VIB_AUTO   = 4'h1;
   localparam logic [3:0] VIB_MANUAL = 4'h2;
   localparam logic [3:0] VIB_RESET  = 4'h3;
   localparam logic [3:0] TRV_OFF    = 4'h0;
   localparam logic [3:0] TRV_ON     = 4'h1;
   localparam logic [3:0] TRV_RESET  = 4'h2;
   localparam logic [3:0] VST_OFF    = 4'h0;
   localparam logic [3:0] VST_PREP   = 4'h1;
   localparam logic [3:0] VST_EXEC   = 4'h2;
   localparam logic [3:0] VST_WARN   = 4'h3;
   localparam logic [3:0] TST_OFF    = 4'h0;
   localparam logic [3:0] TST_EXEC   = 4'h1;
   localparam logic [3:0] TST_WARN   = 4'h2;
   localparam logic [3:0] RUN_STOP   = 4'h0;
   localparam logic [3:0] RUN_GO     = 4'h1;
   localparam logic [3:0] FRIC_WARN  = 4'h3;
   localparam logic [3:0] MULT_ZERO  = 4'h0;
   localparam logic [3:0] MULT_SUBST = 4'h5;

   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [VAL_W-1:0] SELECT_RST = 16'h0000;
   localparam logic [VAL_W-1:0] MULT_RST   = 16'h0000;
   localparam logic [VAL_W-1:0] LIMIT_RST  = 16'h0000;
   localparam logic [VAL_W-1:0] MEAN_RST   = 16'h0000;
   localparam logic [VAL_W-1:0] DEV_RST    = 16'h0000;
   localparam int PREP_SAMPLES_DEF = 1024;

   typedef enum logic [0:0] {
      ST_INIT = 1'b0,
      ST_RUN  = 1'b1
   } phase_t;
endpackage : fp_pkg

/* File: inc/thr_if.sv */
// Threshold settings toward the calculator and result back
interface thr_if;
   logic [15:0] mean;
   logic [15:0] dev;
   logic [3:0]  mult;
   logic [20:0] thr;

   modport calc (input mean, input dev, input mult, output thr);
   modport user (output mean, output dev, output mult, input thr);
endinterface : thr_if

/* File: logic/failure_predictor.sv */
// Behaviour
// R1: Auto mode rewrites mean and deviation from own vibration estimate.
// R2: Computed auto threshold switches vibration selection to manual, 2.
// R3: Threshold in 0.1 % is mean plus deviation times multiplier.
// R4: Multiplier zero counts as five.
// R5: Operator raises multiplier to 6 or more on auto warnings.
// R6: Vibration prediction starts once a threshold is available.
// R7: Warning rises when level in motion exceeds threshold.
// R8: Warning clears when level in motion drops below threshold.
// R9: Vibration selection 3 at power-up drops threshold, selects automatic, 1.
// R10: Travel warning rises when distance exceeds multiplier times limit.
// R11: Travel selection: 0 off, 1 on, 2 reset distance.
// R12: Zero distance limit keeps travel prediction from starting.
// R13: Travel warning holds until selection 0 and a power cycle.
// R14: Travel selection 2 at power-up zeroes distance, selects enabled, 1.
// R15: Status bits 0 to 3 show friction state.
// R16: Status bits 4 to 7: vibration off, preparing, running, warning.
// R17: Status bits 8 to 11: travel off, running, warning.
// R18: Status bits 12 to 15: accumulation stopped or running; rest reserved.
// R19: Vibration selection: 0 off, 1 automatic, 2 manual, 3 reset.
// R20: Reset codes apply only at power-up, before prediction resumes.
//
// Decided for this implementation: the Wishbone interface to the registers.
module failure_predictor
   import fp_pkg::*;
#(
   parameter int PREP_SAMPLES = fp_pkg::PREP_SAMPLES_DEF  // Samples for automatic threshold
)(
   input  wire logic                   clk_i,             // System clock, 40 MHz
   input  wire logic                   rst_i,             // Synchronous reset, active high
   input  wire logic                   restart_i,         // Power cycle request pulse
   input  wire logic                   wb_cyc_i,          // Wishbone cycle
   input  wire logic                   wb_stb_i,          // Wishbone strobe
   input  wire logic                   wb_we_i,           // Wishbone write enable
   input  wire logic [fp_pkg::ADR_W-1:0] wb_adr_i,        // Wishbone byte address
   input  wire logic [3:0]             wb_sel_i,          // Wishbone byte enables
   input  wire logic [fp_pkg::DAT_W-1:0] wb_dat_i,        // Wishbone write data
   output logic      [fp_pkg::DAT_W-1:0] wb_dat_o,        // Wishbone read data
   output logic                        wb_ack_o,          // Wishbone acknowledge
   input  wire logic                   motor_run_i,       // Motor in operation
   input  wire logic                   vib_valid_i,       // Vibration estimate strobe
   input  wire logic [fp_pkg::VAL_W-1:0] vib_level_i,     // Vibration estimate, 0.1 %
   input  wire logic                   travel_valid_i,    // Travel increment strobe
   input  wire logic [fp_pkg::VAL_W-1:0] travel_step_i,   // Travel increment
   input  wire logic [3:0]             friction_state_i,  // Friction prediction state
   output logic                        vibration_warning_o,       // Vibration warning
   output logic                        friction_warning_o,        // Friction warning
   output logic                        travel_distance_warning_o  // Travel warning
);
   import fp_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int CNT_W = $clog2(PREP_SAMPLES + 1);

   phase_t              phase_q;
   logic [VAL_W-1:0]    sel_q, mult_q, limit_q, mean_q, dev_q;
   logic [DIST_W-1:0]   dist_q;
   logic                vib_warn_q, trv_warn_q, fric_warn_q;
   logic                ack_q;
   logic [DAT_W-1:0]    dat_q, rd_d;
   logic [CNT_W-1:0]    prep_cnt_q;
   logic [VAL_W-1:0]    min_q, max_q, lo, hi;
   logic                prep_done;
   logic                thr_ready_q;
   logic [3:0]          vib_sel, trv_sel, dist_mult;
   logic                req, wr;
   logic [IDX_W-1:0]    idx;
   logic                vib_exec, vib_prep, trv_exec, accum_run;
   logic [19:0]         trv_limit;
   logic [DIST_W-1:0]   dist_sum;
   logic [3:0]          vib_st, trv_st, run_st;
   logic [VAL_W-1:0]    auto_mean, auto_dev;

   thr_if thr ();

   if (PREP_SAMPLES < 2 || PREP_SAMPLES > 65535) begin : g_bad_prep
      $error("PREP_SAMPLES out of range");
   end

   // ------------------------------------------------------------
   // Field decode
   // ------------------------------------------------------------
   assign vib_sel   = sel_q[SEL_VIB_LSB +: 4];   // [R19]
   assign trv_sel   = sel_q[SEL_TRV_LSB +: 4];   // [R11]
   assign dist_mult = sel_q[SEL_MUL_LSB +: 4];
   assign req       = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr        = req & wb_we_i;
   assign idx       = wb_adr_i[ADR_W-1:2];

   // Byte-lane write into a 16-bit register
   function automatic logic [VAL_W-1:0] lane_wr(input logic [VAL_W-1:0] old,
                                                input logic [DAT_W-1:0] d,
                                                input logic [3:0] s);
      logic [VAL_W-1:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : lane_wr

   // ------------------------------------------------------------
   // Power-up phase: one init cycle, then run
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         phase_q <= ST_INIT;
      end else begin
         unique case (phase_q)
            ST_INIT: phase_q <= ST_RUN;   // [R20]
            ST_RUN:  phase_q <= ST_RUN;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Configuration registers: software writes, hardware updates win
   // ------------------------------------------------------------
   assign lo        = (vib_level_i < min_q) ? vib_level_i : min_q;
   assign hi        = (vib_level_i > max_q) ? vib_level_i : max_q;
   assign auto_mean = VAL_W'((17'(hi) + 17'(lo)) >> 1);
   assign auto_dev  = VAL_W'((hi - lo) >> 1);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q   <= SELECT_RST;
         mult_q  <= MULT_RST;
         limit_q <= LIMIT_RST;
         mean_q  <= MEAN_RST;
         dev_q   <= DEV_RST;
      end else begin
         if (wr && idx == IDX_SELECT) begin
            sel_q <= lane_wr(sel_q, wb_dat_i, wb_sel_i);
         end
         if (wr && idx == IDX_MULT) begin
            mult_q <= lane_wr(mult_q, wb_dat_i, wb_sel_i);
         end
         if (wr && idx == IDX_LIMIT) begin
            limit_q <= lane_wr(limit_q, wb_dat_i, wb_sel_i);
         end
         if (wr && idx == IDX_VIB_MEAN) begin
            mean_q <= lane_wr(mean_q, wb_dat_i, wb_sel_i);
         end
         if (wr && idx == IDX_VIB_DEV) begin
            dev_q <= lane_wr(dev_q, wb_dat_i, wb_sel_i);
         end
         // Reset codes honoured only in the init cycle
         if (phase_q == ST_INIT) begin
            if (vib_sel == VIB_RESET) begin
               mean_q                  <= MEAN_RST;   // [R9]
               dev_q                   <= DEV_RST;
               sel_q[SEL_VIB_LSB +: 4] <= VIB_AUTO;   // [R9]
            end
            if (trv_sel == TRV_RESET) begin
               sel_q[SEL_TRV_LSB +: 4] <= TRV_ON;     // [R14]
            end
         end else if (prep_done) begin
            mean_q                  <= auto_mean;     // [R1]
            dev_q                   <= auto_dev;      // [R1]
            sel_q[SEL_VIB_LSB +: 4] <= VIB_MANUAL;    // [R2]
         end
      end
   end

   // ------------------------------------------------------------
   // Threshold calculator
   // ------------------------------------------------------------
   assign thr.mean = mean_q;
   assign thr.dev  = dev_q;
   assign thr.mult = mult_q[MULT_VIB_LSB +: 4];

   vib_threshold_calc u_thr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .t     (thr.calc)
   );

   // ------------------------------------------------------------
   // Automatic threshold preparation: min/max over a sample window
   // ------------------------------------------------------------
   assign vib_prep  = (phase_q == ST_RUN) && (vib_sel == VIB_AUTO);
   assign prep_done = vib_prep && vib_valid_i && motor_run_i
                      && (prep_cnt_q == CNT_W'(PREP_SAMPLES - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || !vib_prep) begin
         prep_cnt_q <= '0;
         min_q      <= '1;
         max_q      <= '0;
      end else if (vib_valid_i && motor_run_i) begin
         prep_cnt_q <= prep_done ? '0 : prep_cnt_q + 1'b1;
         min_q      <= lo;
         max_q      <= hi;
      end
   end

   // ------------------------------------------------------------
   // Vibration prediction: runs in manual mode after calculator settles
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || phase_q == ST_INIT || vib_sel != VIB_MANUAL) begin
         thr_ready_q <= 1'b0;
      end else begin
         thr_ready_q <= 1'b1;   // [R6]
      end
   end

   assign vib_exec = thr_ready_q && (vib_sel == VIB_MANUAL);   // [R6]

   // Compare measured level with threshold while the motor moves
   always_ff @(posedge clk_i) begin
      if (rst_i || !vib_exec) begin
         vib_warn_q <= 1'b0;
      end else if (vib_valid_i && motor_run_i) begin
         if (THR_W'(vib_level_i) > thr.thr) begin
            vib_warn_q <= 1'b1;   // [R7]
         end else if (THR_W'(vib_level_i) < thr.thr) begin
            vib_warn_q <= 1'b0;   // [R8]
         end
      end
   end

   // ------------------------------------------------------------
   // Travel distance accumulation and warning
   // ------------------------------------------------------------
   assign trv_exec  = (phase_q == ST_RUN) && (trv_sel == TRV_ON)
                      && (limit_q != '0);                          // [R11] [R12]
   assign accum_run = trv_exec && motor_run_i;
   assign trv_limit = 20'(dist_mult) * 20'(limit_q);
   assign dist_sum  = dist_q + DIST_W'(travel_step_i);

   // Saturating distance counter, zeroed by the reset code at power-up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dist_q <= '0;
      end else if (phase_q == ST_INIT && trv_sel == TRV_RESET) begin
         dist_q <= '0;   // [R14]
      end else if (accum_run && travel_valid_i) begin
         dist_q <= (dist_sum < dist_q) ? '1 : dist_sum;
      end
   end

   // Sticky warning, released only by selection 0 at power-up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trv_warn_q <= 1'b0;
      end else if (phase_q == ST_INIT && trv_sel == TRV_OFF) begin
         trv_warn_q <= 1'b0;   // [R13]
      end else if (trv_exec && dist_q > DIST_W'(trv_limit)) begin
         trv_warn_q <= 1'b1;   // [R10]
      end
   end

   // Friction warning follows its reported state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fric_warn_q <= 1'b0;
      end else begin
         fric_warn_q <= (friction_state_i == FRIC_WARN);
      end
   end

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------
   always_comb begin
      if (vib_warn_q) begin
         vib_st = VST_WARN;
      end else if (vib_exec) begin
         vib_st = VST_EXEC;
      end else if (vib_sel == VIB_AUTO || vib_sel == VIB_MANUAL) begin
         vib_st = VST_PREP;
      end else begin
         vib_st = VST_OFF;
      end
      if (trv_warn_q) begin
         trv_st = TST_WARN;
      end else if (trv_exec) begin
         trv_st = TST_EXEC;
      end else begin
         trv_st = TST_OFF;
      end
      run_st = accum_run ? RUN_GO : RUN_STOP;
   end

   // ------------------------------------------------------------
   // Wishbone read mux and acknowledge
   // ------------------------------------------------------------
   always_comb begin
      rd_d = '0;
      unique case (idx)
         IDX_SELECT:   rd_d[VAL_W-1:0] = sel_q;
         IDX_MULT:     rd_d[VAL_W-1:0] = mult_q;
         IDX_LIMIT:    rd_d[VAL_W-1:0] = limit_q;
         IDX_VIB_MEAN: rd_d[VAL_W-1:0] = mean_q;
         IDX_VIB_DEV:  rd_d[VAL_W-1:0] = dev_q;
         IDX_STATE: begin
            rd_d[ST_FRIC_LSB +: 4] = friction_state_i;   // [R15]
            rd_d[ST_VIB_LSB +: 4]  = vib_st;             // [R16]
            rd_d[ST_TRV_LSB +: 4]  = trv_st;             // [R17]
            rd_d[ST_RUN_LSB +: 4]  = run_st;             // [R18]
         end
         IDX_VIB_THR:  rd_d[THR_W-1:0] = thr.thr;
         IDX_DISTANCE: rd_d = dist_q;
         default:      rd_d = '0;
      endcase
   end

   // One wait state, every address answered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= req;
         if (req && !wb_we_i) begin
            dat_q <= rd_d;
         end
      end
   end

   assign wb_ack_o                  = ack_q;
   assign wb_dat_o                  = dat_q;
   assign vibration_warning_o       = vib_warn_q;
   assign friction_warning_o        = fric_warn_q;
   assign travel_distance_warning_o = trv_warn_q;
endmodule : failure_predictor

/* File: logic/vib_threshold_calc.sv */
module vib_threshold_calc
   import fp_pkg::*;
(
   input  wire logic clk_i,   // System clock
   input  wire logic rst_i,   // Synchronous reset, active high
   thr_if.calc       t        // Settings in, threshold out
);
   logic [3:0]       eff_mult;
   logic [19:0]      prod;
   logic [THR_W-1:0] thr_q;

   // Zero multiplier stands for five
   assign eff_mult = (t.mult == MULT_ZERO) ? MULT_SUBST : t.mult; // [R4]
   assign prod     = 20'(t.dev) * 20'(eff_mult);

   // Mean plus deviation times multiplier, 0.1 % units
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thr_q <= '0;
      end else begin
         thr_q <= THR_W'(t.mean) + THR_W'(prod); // [R3]
      end
   end

   assign t.thr = thr_q;
endmodule : vib_threshold_calc

/* File: verif/fp_sva.sv */
module fp_sva
   import fp_pkg::*;
(
   input wire logic                     clk_i,                     // Clock
   input wire logic                     rst_i,                     // Reset
   input wire logic                     restart_i,                 // Power cycle
   input wire logic                     wb_cyc_i,                  // Cycle
   input wire logic                     wb_stb_i,                  // Strobe
   input wire logic                     wb_we_i,                   // Write
   input wire logic [fp_pkg::ADR_W-1:0] wb_adr_i,                  // Address
   input wire logic [fp_pkg::DAT_W-1:0] wb_dat_o,                  // Read data
   input wire logic                     wb_ack_o,                  // Acknowledge
   input wire logic                     motor_run_i,               // Motor moving
   input wire logic                     vib_valid_i,               // Vibration strobe
   input wire logic                     travel_valid_i,            // Travel strobe
   input wire logic [3:0]               friction_state_i,          // Friction code
   input wire logic                     vibration_warning_o,       // Vibration warning
   input wire logic                     friction_warning_o,        // Friction warning
   input wire logic                     travel_distance_warning_o  // Travel warning
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------
   // Sequences and properties
   // ---------------------------------------------
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_ans; endproperty
   property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   property p_vib_rise;
      $rose(vibration_warning_o) |-> $past(vib_valid_i && motor_run_i);
   endproperty
   property p_vib_fall;
      $fell(vibration_warning_o) |-> $past(vib_valid_i && motor_run_i) || $past(wb_we_i, 2) || $past(restart_i, 3);
   endproperty
   property p_fric; !$past(rst_i) |=> friction_warning_o == ($past(friction_state_i) == FRIC_WARN); endproperty
   property p_trv_hold;
      travel_distance_warning_o && !restart_i && !$past(restart_i) && !$past(restart_i, 2)
         |=> travel_distance_warning_o;
   endproperty
   property p_trv_rise;
      $rose(travel_distance_warning_o) |-> $past(travel_valid_i, 2) || $past(wb_we_i, 2);
   endproperty
   property p_state_hi;
      wb_ack_o && $past(!wb_we_i && wb_adr_i[15:2] == IDX_STATE) |-> wb_dat_o[31:16] == 16'h0000;
   endproperty
   property p_unmapped; wb_ack_o && $past(!wb_we_i && wb_adr_i[15:2] == 14'h0001) |-> wb_dat_o == '0; endproperty
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   a_idle: assert property (p_idle) else $error("ack without request");
   a_vib_rise: assert property (p_vib_rise) else $error("vibration warning rose without sample");
   a_vib_fall: assert property (p_vib_fall) else $error("vibration warning fell without cause");
   a_fric: assert property (p_fric) else $error("friction warning does not follow state");
   a_trv_hold: assert property (p_trv_hold) else $error("travel warning dropped without power cycle");
   a_trv_rise: assert property (p_trv_rise) else $error("travel warning rose without cause");
   a_state_hi: assert property (p_state_hi) else $error("reserved status bits not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : fp_sva

bind failure_predictor fp_sva i_fp_sva (.*);

/* File: verif/tb.sv */
module tb import fp_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0, rst_i = 1'b1, restart_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = '0;
   logic [3:0]       wb_sel_i = 4'h0, friction_state_i = 4'h0;
   logic [DAT_W-1:0] wb_dat_i = '0, wb_dat_o, d;
   logic wb_ack_o, motor_run_i = 1'b0, vib_valid_i = 1'b0, travel_valid_i = 1'b0;
   logic [VAL_W-1:0] vib_level_i = '0, travel_step_i = '0;
   logic vibration_warning_o, friction_warning_o, travel_distance_warning_o;
   int fail_count = 0, n_checks = 0, cyc_n = 0;
   // Mean, deviation, multiplier, threshold
   logic [56:0] rows [4] = '{{16'h0064, 16'h000A, 4'h0, 21'h000096}, {16'h0064, 16'h000A, 4'h3, 21'h000082},
      {16'h0010, 16'h0003, 4'h1, 21'h000013}, {16'hFFFF, 16'hFFFF, 4'hF, 21'h0FFFF0}};
   logic [15:0] lv [4] = '{16'h0014, 16'h003C, 16'h0028, 16'h000A};

   failure_predictor #(.PREP_SAMPLES(4)) i_failure_predictor (.*);

   // Clock and timeout
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 6000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk_reg
   task chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   task wb(input logic w, input logic [IDX_W-1:0] idx, input logic [15:0] v, output logic [31:0] r);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h3;
      wb_dat_i <= {16'h0000, v};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb
   task wr(input logic [IDX_W-1:0] idx, input logic [15:0] v);
      wb(1'b1, idx, v, d);
   endtask : wr
   task rd(input logic [IDX_W-1:0] idx, output logic [31:0] r);
      wb(1'b0, idx, 16'h0000, r);
   endtask : rd
   task fld(input logic [IDX_W-1:0] idx, input int lsb, input logic [3:0] e);
      rd(idx, d);
      chk_reg($sformatf("index %0h bit %0d", idx, lsb), 32'(e), 32'(d[lsb+:4]));
   endtask : fld
   task smp(input logic [15:0] lvl, input logic run);
      @(posedge clk_i);
      vib_valid_i <= 1'b1;
      vib_level_i <= lvl;
      motor_run_i <= run;
      @(posedge clk_i);
      vib_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : smp
   task trv(input logic [15:0] s);
      @(posedge clk_i);
      travel_valid_i <= 1'b1;
      travel_step_i  <= s;
      motor_run_i    <= 1'b1;
      @(posedge clk_i);
      travel_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : trv
   task pwr();
      @(posedge clk_i);
      restart_i <= 1'b1;
      @(posedge clk_i);
      restart_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pwr
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_STATE, d);
      chk_reg("status after reset", 32'h00000000, d);
      wr(IDX_STATE, 16'hFFFF);
      rd(IDX_STATE, d);
      chk_reg("status after write", 32'h00000000, d);
      rd(14'h0001, d);
      chk_reg("unmapped", 32'h00000000, d);
      foreach (rows[i]) begin
         wr(IDX_VIB_MEAN, rows[i][56:41]);
         wr(IDX_VIB_DEV, rows[i][40:25]);
         wr(IDX_MULT, {8'h00, rows[i][24:21], 4'h0});
         rd(IDX_VIB_THR, d);
         chk_reg("threshold", {11'h000, rows[i][20:0]}, d);
      end
      // Manual threshold of 150
      wr(IDX_VIB_MEAN, 16'h0064);
      wr(IDX_VIB_DEV, 16'h000A);
      wr(IDX_MULT, 16'h0000);
      wr(IDX_SELECT, 16'h0020);
      fld(IDX_STATE, ST_VIB_LSB, VST_EXEC);
      smp(16'h0097, 1'b1);
      chk_bit("vib above", 1'b1, vibration_warning_o);
      fld(IDX_STATE, ST_VIB_LSB, VST_WARN);
      smp(16'h0096, 1'b1);
      chk_bit("vib equal", 1'b1, vibration_warning_o);
      smp(16'h0000, 1'b0);
      chk_bit("vib stopped low", 1'b1, vibration_warning_o);
      smp(16'h0095, 1'b1);
      chk_bit("vib below", 1'b0, vibration_warning_o);
      smp(16'h00C8, 1'b0);
      chk_bit("vib stopped high", 1'b0, vibration_warning_o);
      // Automatic threshold from four samples
      wr(IDX_SELECT, 16'h0010);
      fld(IDX_STATE, ST_VIB_LSB, VST_PREP);
      foreach (lv[i]) smp(lv[i], 1'b1);
      chk_bit("vib auto", 1'b0, vibration_warning_o);
      rd(IDX_VIB_MEAN, d);
      chk_reg("auto mean", 32'h00000023, d);
      rd(IDX_VIB_DEV, d);
      chk_reg("auto deviation", 32'h00000019, d);
      fld(IDX_SELECT, SEL_VIB_LSB, VIB_MANUAL);
      wr(IDX_MULT, 16'h0060);
      rd(IDX_VIB_THR, d);
      chk_reg("auto threshold", 32'h000000B9, d);
      // Threshold reset at power cycle
      wr(IDX_SELECT, 16'h0030);
      fld(IDX_SELECT, SEL_VIB_LSB, VIB_RESET);
      pwr();
      fld(IDX_SELECT, SEL_VIB_LSB, VIB_AUTO);
      rd(IDX_VIB_MEAN, d);
      chk_reg("mean after reset", 32'h00000000, d);
      // Travel limit 2 times 10
      wr(IDX_SELECT, 16'h2100);
      fld(IDX_STATE, ST_TRV_LSB, TST_OFF);
      wr(IDX_LIMIT, 16'h000A);
      fld(IDX_STATE, ST_TRV_LSB, TST_EXEC);
      trv(16'h0014);
      rd(IDX_DISTANCE, d);
      chk_reg("distance", 32'h00000014, d);
      chk_bit("trv at limit", 1'b0, travel_distance_warning_o);
      fld(IDX_STATE, ST_RUN_LSB, RUN_GO);
      trv(16'h0001);
      chk_bit("trv over", 1'b1, travel_distance_warning_o);
      fld(IDX_STATE, ST_TRV_LSB, TST_WARN);
      @(posedge clk_i);
      motor_run_i <= 1'b0;
      fld(IDX_STATE, ST_RUN_LSB, RUN_STOP);
      pwr();
      chk_bit("trv kept on", 1'b1, travel_distance_warning_o);
      wr(IDX_SELECT, 16'h2000);
      chk_bit("trv kept off", 1'b1, travel_distance_warning_o);
      pwr();
      chk_bit("trv cleared", 1'b0, travel_distance_warning_o);
      wr(IDX_SELECT, 16'h2200);
      pwr();
      rd(IDX_DISTANCE, d);
      chk_reg("distance reset", 32'h00000000, d);
      fld(IDX_SELECT, SEL_TRV_LSB, TRV_ON);
      // Friction codes
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         friction_state_i <= 4'(k);
         fld(IDX_STATE, ST_FRIC_LSB, 4'(k));
         chk_bit("friction warning", k == 3, friction_warning_o);
      end
      report_and_stop();
   end
endmodule : tb
